// file: inc/lmei_pkg.sv
// Package: constants, register map and types of the limit monitor and error indicator
package lmei_pkg;
  localparam int CLK_HZ = 100_000_000;
  // Flash timing, in milliseconds
  localparam int FLASH_MS = 250;
  localparam int PAUSE_MS = 1000;
  localparam int FLASH_CYC = FLASH_MS * (CLK_HZ / 1000);
  localparam int PAUSE_CYC = PAUSE_MS * (CLK_HZ / 1000);
  // Sample period, kept well below the 50 us excursion bound
  localparam int EXCURSION_US = 50;
  localparam int SAMPLE_US = 20;
  localparam logic [15:0] SAMPLE_CYC = 16'(SAMPLE_US * (CLK_HZ / 1_000_000));
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_UPPER = 8'h04;
  localparam logic [7:0] REG_LOWER = 8'h08;
  localparam logic [7:0] REG_HYST = 8'h0C;
  localparam logic [7:0] REG_DELAY = 8'h10;
  localparam logic [7:0] REG_CODE_ERR = 8'h14;
  localparam logic [7:0] REG_CODE_WARN = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;
  localparam logic [7:0] REG_ACK = 8'h20;
  // Control field positions
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_FN_LSB = 2;
  localparam int CTRL_RLY_LSB = 4;
  localparam int CTRL_POL_BIT = 6;
  localparam int HALF_HI_LSB = 16;
  // Reset values
  localparam logic [15:0] RST_UPPER = 16'hFFFF;
  localparam logic [15:0] RST_ZERO16 = 16'h0000;
  localparam logic [31:0] RST_CODES = 32'h0000_0000;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Monitored quantity, function and relay selections
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_VOLT = 2'h1;
  localparam logic [1:0] SEL_CURR = 2'h2;
  localparam logic [1:0] SEL_POW = 2'h3;
  localparam logic [1:0] FN_ABOVE = 2'h0;
  localparam logic [1:0] FN_BELOW = 2'h1;
  localparam logic [1:0] FN_INSIDE = 2'h2;
  localparam logic [1:0] FN_OUTSIDE = 2'h3;
  localparam logic [1:0] RLY_WARN = 2'h0;
  localparam logic [1:0] RLY_RUN = 2'h1;
  localparam logic [1:0] RLY_OK = 2'h2;
  typedef enum logic [2:0] {FS_SCAN, FS_ON, FS_OFF, FS_PAUSE} lmei_fs_t;
endpackage

// file: src/lmei_top.sv
// Limit monitor and error indicator with an AXI4-Lite register slave
// Functional notes
// - Errors and warnings share one code format; each pending entry flashes in turn.
// - After the last pending entry the sequence restarts at the first.
// - Code value 0..F flashes as value plus one, 1..16 flashes.
// - A dark pause separates flash groups and never stands for a value.
// - An error stays latched until its cause is gone and acknowledged.
// - Acknowledge comes from front button, host write or external rising edge.
// - The monitor watches one selected quantity: voltage, current or power.
// - Selection none disables the monitor and it drives no relay.
// - Active condition is above, below, inside window or outside window.
// - Each threshold has a hysteresis band on one side.
// - Hysteresis of zero uses the same threshold both ways.
// - In the active range the delay counter counts up once per sample.
// - Falling back before the limit counts down; re-entering counts up again.
// - Relay switches only when the delay counter reaches its limit.
// - Active to inactive uses its own delay limit on the same shared up and down delay counter.
// - Monitor drives the warning, running or healthy relay, as selected.
// - A bit sets the relay state when active; inactive gives the opposite.
// - Quantity is sampled periodically; very short excursions may be missed.
// - Monitor runs from loaded registers without any host present.
// - A code is group flashes, a pause, then detail flashes.
// - Codes are 16 groups with 16 details each.
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module lmei_top
  import lmei_pkg::*;
#(
  parameter int FLASH_CYCLES = lmei_pkg::FLASH_CYC,
  parameter int PAUSE_CYCLES = lmei_pkg::PAUSE_CYC
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [7:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  input wire logic [15:0] meas_volt_i,
  input wire logic [15:0] meas_curr_i,
  input wire logic [15:0] meas_pow_i,
  input wire logic [3:0] err_cause_i,
  input wire logic [3:0] warn_i,
  input wire logic ack_button_i,
  input wire logic ext_ack_i,
  input wire logic ok_base_i,
  input wire logic run_base_i,
  input wire logic warn_base_i,
  output logic err_led_o,
  output logic warn_led_o,
  output logic relay_ok_o,
  output logic relay_run_o,
  output logic relay_warn_o
);
  import lmei_pkg::*;

  typedef struct packed {
    logic btn1, btn2, btn3, xa1, xa2, xa3;
    logic [1:0] sel, fn, rsel;
    logic pol;
    logic [15:0] upper, lower, hu, hl, don, doff;
    logic [31:0] code_e, code_w;
    logic [3:0] err_lat;
    logic mon_act, tick;
    logic [15:0] cnt, smp;
    lmei_fs_t fs;
    logic [2:0] idx;
    logic dph;
    logic [4:0] fcnt;
    logic [31:0] tmr;
    logic err_led, warn_led, rly_ok, rly_run, rly_warn;
    logic aw_got, w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
  } lmei_state_t;

  lmei_state_t s, next_s;
  logic ack_any;
  logic in_rng;
  logic [15:0] meas;
  logic [7:0] pend;

  // Byte-lane merge of a write into a 32-bit word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Saturating add and subtract keep hysteresis bands from wrapping
  function automatic logic [15:0] add_sat(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] t;
    t = {1'b0, a} + {1'b0, b};
    return t[16] ? 16'hFFFF : t[15:0];
  endfunction

  function automatic logic [15:0] sub_sat(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? 16'(a - b) : 16'h0000;
  endfunction

  // Eight-bit code of a pending slot: low nibble detail, high nibble group
  function automatic logic [7:0] code_of(input logic [2:0] i, input logic [31:0] ce,
                                         input logic [31:0] cw);
    return i[2] ? cw[8*i[1:0] +: 8] : ce[8*i[1:0] +: 8];
  endfunction

  assign pend = {warn_i, s.err_lat};

  // Quantity select and range test; the relaxed threshold applies once active
  always_comb begin
    case (s.sel)
      SEL_VOLT: meas = meas_volt_i;
      SEL_CURR: meas = meas_curr_i;
      SEL_POW: meas = meas_pow_i;
      default: meas = 16'h0000;
    endcase
    case (s.fn)
      FN_ABOVE: in_rng = meas > (s.mon_act ? sub_sat(s.upper, s.hu) : s.upper);
      FN_BELOW: in_rng = meas < (s.mon_act ? add_sat(s.lower, s.hl) : s.lower);
      FN_INSIDE: in_rng = s.mon_act ?
          (meas > sub_sat(s.lower, s.hl) && meas < add_sat(s.upper, s.hu)) :
          (meas > s.lower && meas < s.upper);
      default: in_rng = s.mon_act ?
          (meas > sub_sat(s.upper, s.hu) || meas < add_sat(s.lower, s.hl)) :
          (meas > s.upper || meas < s.lower);
    endcase
  end

  // Next-state logic for bus, error latch, monitor and flash sequencer
  always_comb begin
    logic host_ack;
    logic [15:0] lim;
    logic [7:0] cd;
    logic [31:0] mw;
    host_ack = 1'b0;
    mw = 32'h0000_0000;
    lim = 16'h0000;
    cd = 8'h00;
    next_s = s;
    // Pin synchronisers, third stage only for edge detection
    next_s.btn1 = ack_button_i;
    next_s.btn2 = s.btn1;
    next_s.btn3 = s.btn2;
    next_s.xa1 = ext_ack_i;
    next_s.xa2 = s.xa1;
    next_s.xa3 = s.xa2;
    // Write channel: address and data taken in either order
    if (s_axi_awvalid_i && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s.wready) begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata_i;
      next_s.wstrb = s_axi_wstrb_i;
    end
    if (s.bvalid && s_axi_bready_i) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      if (s.awaddr == REG_CTRL) begin
        if (s.wstrb[0]) begin
          next_s.sel = s.wdata[CTRL_SEL_LSB +: 2];
          next_s.fn = s.wdata[CTRL_FN_LSB +: 2];
          next_s.rsel = s.wdata[CTRL_RLY_LSB +: 2];
          next_s.pol = s.wdata[CTRL_POL_BIT];
        end
      end else if (s.awaddr == REG_UPPER) begin
        mw = merge({16'h0000, s.upper}, s.wdata, s.wstrb);
        next_s.upper = mw[15:0];
      end else if (s.awaddr == REG_LOWER) begin
        mw = merge({16'h0000, s.lower}, s.wdata, s.wstrb);
        next_s.lower = mw[15:0];
      end else if (s.awaddr == REG_HYST) begin
        {next_s.hl, next_s.hu} = merge({s.hl, s.hu}, s.wdata, s.wstrb);
      end else if (s.awaddr == REG_DELAY) begin
        {next_s.doff, next_s.don} = merge({s.doff, s.don}, s.wdata, s.wstrb);
      end else if (s.awaddr == REG_CODE_ERR) begin
        next_s.code_e = merge(s.code_e, s.wdata, s.wstrb);
      end else if (s.awaddr == REG_CODE_WARN) begin
        next_s.code_w = merge(s.code_w, s.wdata, s.wstrb);
      end else if (s.awaddr == REG_ACK) begin
        host_ack = s.wstrb[0] && s.wdata[0];
      end else if (s.awaddr != REG_STATUS) begin
        next_s.bresp = RESP_SLVERR;
      end
    end
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;
    // Read channel, one read outstanding
    if (s.rvalid && s_axi_rready_i) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = 32'h0000_0000;
      if (s_axi_araddr_i == REG_CTRL) begin
        next_s.rdata[6:0] = {s.pol, s.rsel, s.fn, s.sel};
      end else if (s_axi_araddr_i == REG_UPPER) begin
        next_s.rdata[15:0] = s.upper;
      end else if (s_axi_araddr_i == REG_LOWER) begin
        next_s.rdata[15:0] = s.lower;
      end else if (s_axi_araddr_i == REG_HYST) begin
        next_s.rdata = {s.hl, s.hu};
      end else if (s_axi_araddr_i == REG_DELAY) begin
        next_s.rdata = {s.doff, s.don};
      end else if (s_axi_araddr_i == REG_CODE_ERR) begin
        next_s.rdata = s.code_e;
      end else if (s_axi_araddr_i == REG_CODE_WARN) begin
        next_s.rdata = s.code_w;
      end else if (s_axi_araddr_i == REG_STATUS) begin
        next_s.rdata[HALF_HI_LSB +: 16] = s.cnt;
        next_s.rdata[11:0] = {s.rly_warn, s.rly_run, s.rly_ok, warn_i, s.mon_act, s.err_lat};
      end else if (s_axi_araddr_i != REG_ACK) begin
        next_s.rresp = RESP_SLVERR;
      end
    end
    next_s.arready = !next_s.rvalid;
    // Error latch: a live cause wins over an acknowledge
    ack_any = (s.btn2 && !s.btn3) || (s.xa2 && !s.xa3) || host_ack;
    next_s.err_lat = (s.err_lat & ~({4{ack_any}} & ~err_cause_i)) | err_cause_i;
    // Sample tick for the monitor
    next_s.tick = 1'b0;
    next_s.smp = 16'(s.smp + 16'h0001);
    if (s.smp >= 16'(SAMPLE_CYC - 16'h0001)) begin
      next_s.smp = 16'h0000;
      next_s.tick = 1'b1;
    end
    // Delay counters: one counter reused for each direction
    lim = s.mon_act ? s.doff : s.don;
    if (s.sel == SEL_NONE) begin
      next_s.mon_act = 1'b0;
      next_s.cnt = 16'h0000;
    end else if (s.tick) begin
      if (in_rng != s.mon_act) begin
        if (lim == 16'h0000 || 16'(s.cnt + 16'h0001) >= lim) begin
          next_s.mon_act = in_rng;
          next_s.cnt = 16'h0000;
        end else begin
          next_s.cnt = 16'(s.cnt + 16'h0001);
        end
      end else if (s.cnt != 16'h0000) begin
        next_s.cnt = 16'(s.cnt - 16'h0001);
      end
    end
    // Relays follow device state unless claimed by an enabled monitor
    next_s.rly_ok = ok_base_i;
    next_s.rly_run = run_base_i;
    next_s.rly_warn = warn_base_i;
    if (next_s.sel != SEL_NONE) begin
      if (next_s.rsel == RLY_WARN) begin
        next_s.rly_warn = next_s.mon_act ~^ next_s.pol;
      end else if (next_s.rsel == RLY_RUN) begin
        next_s.rly_run = next_s.mon_act ~^ next_s.pol;
      end else if (next_s.rsel == RLY_OK) begin
        next_s.rly_ok = next_s.mon_act ~^ next_s.pol;
      end
    end
    // Flash sequencer over the eight pending slots
    cd = code_of(s.idx, s.code_e, s.code_w);
    if (s.tmr != 32'h0000_0000) begin
      next_s.tmr = s.tmr - 32'h0000_0001;
    end
    case (s.fs)
      FS_SCAN: begin
        next_s.dph = 1'b0;
        if (pend[s.idx]) begin
          next_s.fs = FS_ON;
          next_s.fcnt = 5'({1'b0, cd[7:4]} + 5'h01);
          next_s.tmr = 32'(FLASH_CYCLES);
        end else begin
          next_s.idx = 3'(s.idx + 3'h1);
        end
      end
      FS_ON: begin
        if (s.tmr == 32'h0000_0000) begin
          next_s.fs = FS_OFF;
          next_s.fcnt = 5'(s.fcnt - 5'h01);
          next_s.tmr = 32'(FLASH_CYCLES);
        end
      end
      FS_OFF: begin
        if (s.tmr == 32'h0000_0000) begin
          next_s.fs = (s.fcnt == 5'h00) ? FS_PAUSE : FS_ON;
          next_s.tmr = (s.fcnt == 5'h00) ? 32'(PAUSE_CYCLES) : 32'(FLASH_CYCLES);
        end
      end
      default: begin
        if (s.tmr == 32'h0000_0000) begin
          if (!s.dph) begin
            next_s.dph = 1'b1;
            next_s.fs = FS_ON;
            next_s.fcnt = 5'({1'b0, cd[3:0]} + 5'h01);
            next_s.tmr = 32'(FLASH_CYCLES);
          end else begin
            next_s.fs = FS_SCAN;
            next_s.idx = 3'(s.idx + 3'h1);
          end
        end
      end
    endcase
    // The pause is dark; it carries no value
    next_s.err_led = (next_s.fs == FS_ON) && !next_s.idx[2];
    next_s.warn_led = (next_s.fs == FS_ON) && next_s.idx[2];
    if (reset_i) begin
      next_s = '0;
      next_s.upper = RST_UPPER;
      next_s.lower = RST_ZERO16;
      next_s.code_e = RST_CODES;
      next_s.code_w = RST_CODES;
      next_s.fs = FS_SCAN;
    end
  end

  // State register
  always_ff @(posedge mclk_i) begin
    s <= next_s;
  end

  assign s_axi_awready_o = s.awready;
  assign s_axi_wready_o = s.wready;
  assign s_axi_bvalid_o = s.bvalid;
  assign s_axi_bresp_o = s.bresp;
  assign s_axi_arready_o = s.arready;
  assign s_axi_rvalid_o = s.rvalid;
  assign s_axi_rdata_o = s.rdata;
  assign s_axi_rresp_o = s.rresp;
  assign err_led_o = s.err_led;
  assign warn_led_o = s.warn_led;
  assign relay_ok_o = s.rly_ok;
  assign relay_run_o = s.rly_run;
  assign relay_warn_o = s.rly_warn;

  // Code of the slot under the scan pointer, watched by the flash count check
  logic [7:0] cd_now;
  assign cd_now = code_of(s.idx, s.code_e, s.code_w);

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  err_set_a: assert property (err_cause_i != 4'h0 |=>
      (s.err_lat & $past(err_cause_i)) == $past(err_cause_i))
    else $error("error latch missed a cause");
  err_clear_a: assert property ((($past(s.err_lat) & ~s.err_lat) != 4'h0) |->
      $past(ack_any) && (($past(s.err_lat) & ~s.err_lat & $past(err_cause_i)) == 4'h0))
    else $error("error cleared without acknowledge");
  mon_off_a: assert property (s.sel == SEL_NONE |=> !s.mon_act && s.cnt == 16'h0000)
    else $error("monitor active while disabled");
  act_limit_a: assert property ($rose(s.mon_act) |-> $past(s.tick) &&
      ($past(s.don) == 16'h0000 || 16'($past(s.cnt) + 16'h0001) >= $past(s.don)))
    else $error("monitor switched before delay limit");
  cnt_tick_a: assert property (!s.tick && s.sel != SEL_NONE && s.sel == $past(s.sel) |->
      s.cnt == $past(s.cnt) || $past(s.tick))
    else $error("delay counter moved off tick");
  cnt_down_a: assert property (s.tick && s.sel != SEL_NONE && in_rng == s.mon_act &&
      s.cnt != 16'h0000 |=> s.cnt == 16'($past(s.cnt) - 16'h0001))
    else $error("delay counter did not count down");
  relay_pol_a: assert property (s.sel != SEL_NONE && s.rsel == RLY_WARN |->
      s.rly_warn == (s.mon_act == s.pol))
    else $error("relay state does not follow monitor");
  grp_count_a: assert property (s.fs == FS_SCAN && pend[s.idx] |=>
      s.fs == FS_ON && s.fcnt == 5'({1'b0, $past(cd_now[7:4])} + 5'h01))
    else $error("group flash count wrong");
  pause_dark_a: assert property (s.fs == FS_PAUSE |-> !s.err_led && !s.warn_led)
    else $error("led lit during pause");
  idx_wrap_a: assert property (s.fs == FS_SCAN && !pend[s.idx] |=>
      s.idx == 3'($past(s.idx) + 3'h1))
    else $error("scan did not advance");
  bresp_hold_a: assert property (s.bvalid && !s_axi_bready_i |=> s.bvalid)
    else $error("write response dropped");
endmodule // lmei_top
`default_nettype wire

// file: testbench/lmei_bench.sv
// Self-checking bench: register bus, flash codes, acknowledge and limit monitor
`timescale 1ns/1ps
`default_nettype none
module lmei_bench;
  import lmei_pkg::*;
  typedef struct {logic [1:0] resp; logic [31:0] mask; logic [31:0] val;} lmei_rexp_t;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] err_cause = 4'h0, warn = 4'h0, wstrb = 4'hF;
  logic [15:0] volt = 16'h0, curr = 16'h0, pw = 16'h0;
  logic button = 1'b0, ok_b = 1'b0, run_b = 1'b0, warn_b = 1'b0, ack_req = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ext_ack, err_led, warn_led;
  logic r_ok, r_run, r_warn, ec_v, wc_v;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] ec, wc;
  int num_errors = 0, checks = 0, cyc = 0;
  int act_v[4] = '{1500, 100, 500, 1500};
  int idle_v[4] = '{500, 500, 1500, 500};
  logic [1:0] exp_wr[$];
  lmei_rexp_t exp_rd[$];
  lmei_rexp_t e;
  logic [7:0] exp_ec[$], exp_wc[$];

  // Free-running 100 MHz clock
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end

  // Short flash and pause lengths keep the run brief
  lmei_top #(.FLASH_CYCLES(4), .PAUSE_CYCLES(10)) dut (
    .mclk_i(mclk_i), .reset_i(reset_i),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .meas_volt_i(volt), .meas_curr_i(curr), .meas_pow_i(pw),
    .err_cause_i(err_cause), .warn_i(warn), .ack_button_i(button), .ext_ack_i(ext_ack),
    .ok_base_i(ok_b), .run_base_i(run_b), .warn_base_i(warn_b),
    .err_led_o(err_led), .warn_led_o(warn_led),
    .relay_ok_o(r_ok), .relay_run_o(r_run), .relay_warn_o(r_warn)
  );

  // Gap threshold sits between one flash gap and a full pause
  lmei_panel_model #(.GAP_CYC(7)) err_pm (
    .mclk_i(mclk_i), .reset_i(reset_i), .led_i(err_led), .ack_req_i(ack_req),
    .ext_ack_o(ext_ack), .code_valid_o(ec_v), .code_o(ec)
  );
  lmei_panel_model #(.GAP_CYC(7)) warn_pm (
    .mclk_i(mclk_i), .reset_i(reset_i), .led_i(warn_led), .ack_req_i(1'b0),
    .ext_ack_o(), .code_valid_o(wc_v), .code_o(wc)
  );

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_done;
    logic w_done;
    @(posedge mclk_i);
    exp_wr.push_back(r);
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge mclk_i);
      if (!aw_done && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (!w_done && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    do @(posedge mclk_i); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v,
                    input logic [1:0] r);
    lmei_rexp_t x;
    @(posedge mclk_i);
    x.resp = r;
    x.mask = m;
    x.val = v;
    exp_rd.push_back(x);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk_i); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  task automatic st(input logic [31:0] m, input logic [31:0] v);
    rd(REG_STATUS, m, v, RESP_OKAY);
  endtask

  // Only the selected input carries v; the others carry o to expose a wrong pick
  task automatic setq(input int s, input int v, input int o);
    volt <= 16'((s == 1) ? v : o);
    curr <= 16'((s == 2) ? v : o);
    pw <= 16'((s == 3) ? v : o);
  endtask

  // Results are matched against the oldest pending expectation
  always @(posedge mclk_i) begin
    cyc++;
    if ((bvalid & bready) === 1'b1 && exp_wr.size() > 0) begin
      check("bresp", 32'(bresp), 32'(exp_wr.pop_front()));
    end
    if ((rvalid & rready) === 1'b1 && exp_rd.size() > 0) begin
      e = exp_rd.pop_front();
      check("rresp", 32'(rresp), 32'(e.resp));
      check("rdata", rdata & e.mask, e.val);
    end
    if (ec_v === 1'b1 && exp_ec.size() > 0) begin
      check("err_code", 32'(ec), 32'(exp_ec.pop_front()));
    end
    if (wc_v === 1'b1 && exp_wc.size() > 0) begin
      check("warn_code", 32'(wc), 32'(exp_wc.pop_front()));
    end
    if (cyc > 80000) begin
      num_errors++;
      print_verdict();
    end
  end

  initial begin
    logic [3:0] r0;
    logic [3:0] r1;
    logic [7:0] w;
    int i;
    void'($urandom(70295));
    r0 = 4'($urandom);
    r1 = 4'($urandom);
    w = 8'($urandom);
    repeat (8) @(posedge mclk_i);
    reset_i <= 1'b0;
    tick(2);
    // Reset values, an unmapped place and the write-only acknowledge
    rd(REG_CTRL, 32'hFFFFFFFF, 32'h0, RESP_OKAY);
    rd(REG_UPPER, 32'hFFFFFFFF, 32'h0000FFFF, RESP_OKAY);
    rd(REG_HYST, 32'hFFFFFFFF, 32'h0, RESP_OKAY);
    rd(REG_DELAY, 32'hFFFFFFFF, 32'h0, RESP_OKAY);
    rd(8'h24, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
    wr(8'h24, 32'hFFFFFFFF, RESP_SLVERR);
    rd(REG_ACK, 32'hFFFFFFFF, 32'h0, RESP_OKAY);
    // One byte lane only: the other lane keeps its reset value
    wstrb <= 4'h2;
    wr(REG_UPPER, 32'h0000AB00, RESP_OKAY);
    wstrb <= 4'hF;
    rd(REG_UPPER, 32'hFFFFFFFF, 32'h0000ABFF, RESP_OKAY);
    // Two errors and a warning loop as group plus detail codes
    wr(REG_CODE_ERR, {16'h0, 4'h0, r1, 4'hF, r0}, RESP_OKAY);
    wr(REG_CODE_WARN, {24'h0, w}, RESP_OKAY);
    for (i = 0; i < 2; i++) begin
      exp_ec.push_back({4'hF, r0});
      exp_ec.push_back({4'h0, r1});
      exp_wc.push_back(w);
    end
    err_cause <= 4'h1;
    warn <= 4'h1;
    i = 0;
    while (err_led !== 1'b1 && i < 100) begin
      @(posedge mclk_i);
      i++;
    end
    err_cause <= 4'h3;
    i = 0;
    while (exp_ec.size() + exp_wc.size() > 0 && i < 5000) begin
      @(posedge mclk_i);
      i++;
    end
    check("codes_left", 32'(exp_ec.size() + exp_wc.size()), 32'h0);
    // Latched errors clear only when the cause is gone and acknowledged
    err_cause <= 4'h1;
    warn <= 4'h0;
    st(32'hF, 32'h3);
    ack_req <= 1'b1;
    @(posedge mclk_i);
    ack_req <= 1'b0;
    tick(10);
    st(32'hF, 32'h1);
    err_cause <= 4'h0;
    tick(2);
    st(32'hF, 32'h1);
    wr(REG_ACK, 32'h1, RESP_OKAY);
    tick(4);
    st(32'hF, 32'h0);
    err_cause <= 4'h4;
    tick(2);
    err_cause <= 4'h0;
    tick(2);
    st(32'hF, 32'h4);
    button <= 1'b1;
    tick(8);
    button <= 1'b0;
    st(32'hF, 32'h0);
    // Every function, quantity and relay with zero delay and no hysteresis
    wr(REG_LOWER, 32'd200, RESP_OKAY);
    wr(REG_UPPER, 32'd1000, RESP_OKAY);
    for (i = 0; i < 4; i++) begin
      wr(REG_CTRL, {25'h0, 1'b1, 2'(i % 3), 2'(i), 2'(i % 3 + 1)}, RESP_OKAY);
      setq(i % 3 + 1, idle_v[i], act_v[i]);
      tick(2500);
      st(32'hE10, 32'h0);
      setq(i % 3 + 1, act_v[i], idle_v[i]);
      tick(2500);
      st(32'hE10, 32'h10 | (32'h1 << (11 - i % 3)));
    end
    // Hysteresis band and delays, relay open while active
    wr(REG_CTRL, 32'h11, RESP_OKAY);
    volt <= 16'd0;
    tick(2500);
    wr(REG_HYST, 32'd100, RESP_OKAY);
    wr(REG_DELAY, 32'h0002_0003, RESP_OKAY);
    volt <= 16'd1100;
    tick(2500);
    st(32'hE10, 32'h400);
    // Falling back before the limit drains the counter to zero
    volt <= 16'd0;
    tick(5000);
    st(32'hFFFF0E10, 32'h400);
    volt <= 16'd1100;
    tick(7000);
    st(32'hE10, 32'h10);
    volt <= 16'd950;
    tick(8000);
    st(32'hE10, 32'h10);
    volt <= 16'd850;
    tick(1000);
    st(32'hE10, 32'h10);
    tick(5000);
    st(32'hE10, 32'h400);
    // Selection none: no monitor action, relays follow the device state
    ok_b <= 1'b1;
    run_b <= 1'b1;
    warn_b <= 1'b1;
    volt <= 16'd1100;
    wr(REG_CTRL, 32'h40, RESP_OKAY);
    tick(5000);
    st(32'hE10, 32'hE00);
    print_verdict();
  end
endmodule // lmei_bench
`default_nettype wire

// file: testbench/lmei_panel_model.sv
// Far-side model: reads LED flash codes and drives the external acknowledge pin
`timescale 1ns/1ps
`default_nettype none
module lmei_panel_model #(
  parameter int GAP_CYC = 7
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic led_i,
  input wire logic ack_req_i,
  output logic ext_ack_o = 1'b0,
  output logic code_valid_o = 1'b0,
  output logic [7:0] code_o = 8'h00
);
  logic prev = 1'b0;
  logic half = 1'b0;
  logic [3:0] grp = 4'h0;
  int cnt = 0;
  int dark = 0;
  int ack_cnt = 0;

  // Count rising flashes; a dark run longer than a flash gap closes a group
  always @(posedge mclk_i) begin
    code_valid_o <= 1'b0;
    if (reset_i) begin
      prev <= 1'b0;
      half <= 1'b0;
      cnt <= 0;
      dark <= 0;
    end else begin
      prev <= led_i;
      dark <= led_i ? 0 : dark + 1;
      if (led_i && !prev) begin
        cnt <= cnt + 1;
      end
      // Flash count minus one is the nibble; the long dark is only a separator
      if (!led_i && dark == GAP_CYC && cnt > 0) begin
        cnt <= 0;
        if (!half) begin
          grp <= 4'(cnt - 1);
          half <= 1'b1;
        end else begin
          code_o <= {grp, 4'(cnt - 1)};
          code_valid_o <= 1'b1;
          half <= 1'b0;
        end
      end
    end
  end

  // Held high for several cycles so the synchroniser surely sees a clean rising edge
  always @(posedge mclk_i) begin
    ack_cnt <= ack_req_i ? 6 : (ack_cnt > 0 ? ack_cnt - 1 : 0);
    ext_ack_o <= (ack_cnt > 0);
  end
endmodule // lmei_panel_model
`default_nettype wire
